/* bench/shift_rotate_word_unit_checker.sv */
`timescale 1ns/1ps
module shift_rotate_word_unit_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [15:0] timer_present_value,
    input wire logic [15:0] counter_present_value,
    input wire logic busy_retained_in,
    input wire logic carry_flag,
    input wire logic execution_error_flag,
    input wire logic block_op_busy_flag,
    input wire logic error_led
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire rd_done = psel && penable && pready && !pwrite;
    wire err_clear = psel && penable && pready && pwrite && pwdata[1]
        && paddr == shift_rotate_pkg::STATUS_OFS;

    property p_led_follows;
        error_led == execution_error_flag;
    endproperty
    a_led_follows: assert property (p_led_follows)
        else $error("error indicator differs from error flag");
    property p_err_sticky;
        execution_error_flag && !err_clear |=> execution_error_flag;
    endproperty
    a_err_sticky: assert property (p_err_sticky)
        else $error("error flag dropped without a clear");
    property p_busy_ends;
        $rose(block_op_busy_flag) && $past(presetn, 2) |-> ##[1:70] !block_op_busy_flag;
    endproperty
    a_busy_ends: assert property (p_busy_ends)
        else $error("busy flag not cleared after block operation");
    property p_retain;
        presetn && !$past(presetn) |=> block_op_busy_flag == $past(busy_retained_in);
    endproperty
    a_retain: assert property (p_retain)
        else $error("busy flag not restored after reset");
    property p_slverr_ready;
        pslverr |-> pready;
    endproperty
    a_slverr_ready: assert property (p_slverr_ready)
        else $error("slave error without ready");
    property p_unmapped_zero;
        rd_done && pslverr |-> prdata == 32'h0000_0000;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero)
        else $error("unmapped read not zero");
    property p_status_map;
        rd_done && paddr == shift_rotate_pkg::STATUS_OFS |->
            prdata == {29'h0000_0000, block_op_busy_flag, execution_error_flag, carry_flag};
    endproperty
    a_status_map: assert property (p_status_map)
        else $error("status read differs from flag outputs");
    property p_ctrl_rsvd;
        rd_done && paddr == shift_rotate_pkg::CTRL_OFS |-> prdata[31:12] == 20'h00000;
    endproperty
    a_ctrl_rsvd: assert property (p_ctrl_rsvd)
        else $error("reserved control bits read nonzero");
    c_busy: cover property ($rose(block_op_busy_flag));
    c_err: cover property ($rose(execution_error_flag));
    c_slverr: cover property (pslverr);
endmodule : shift_rotate_word_unit_checker

bind shift_rotate_word_unit shift_rotate_word_unit_checker shift_rotate_word_unit_checker_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_present_value(timer_present_value),
    .counter_present_value(counter_present_value), .busy_retained_in(busy_retained_in),
    .carry_flag(carry_flag), .execution_error_flag(execution_error_flag),
    .block_op_busy_flag(block_op_busy_flag), .error_led(error_led)
);

/* bench/tb.sv */
`timescale 1ns/1ps
module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [15:0] timer_present_value = 16'h0002;
    logic [15:0] counter_present_value = 16'h0003;
    logic busy_retained_in = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, carry_flag, execution_error_flag, block_op_busy_flag, error_led;
    logic want = 1'b0;
    logic busy_seen = 1'b0;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;
    localparam logic [11:0] CT_OFS = shift_rotate_pkg::CTRL_OFS;
    localparam logic [11:0] ST_OFS = shift_rotate_pkg::STATUS_OFS;
    integer seed = 32'h1B4199BB;
    logic [31:0] exp_q[$];
    logic [31:0] m_q[$];
    string name_q[$];
    shift_rotate_pkg::src_e dsrc[4] = '{shift_rotate_pkg::SRC_CONST,
        shift_rotate_pkg::SRC_TIMER, shift_rotate_pkg::SRC_COUNTER, shift_rotate_pkg::SRC_BITS};
    logic [15:0] dhi[4] = '{16'h04D2, 16'h0D80, 16'h1A2C, 16'h1B58};
    logic [15:0] dlo[4] = '{16'h1626, 16'h1B58, 16'h0000, 16'h0000};

    shift_rotate_word_unit shift_rotate_word_unit_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_present_value(timer_present_value),
        .counter_present_value(counter_present_value), .busy_retained_in(busy_retained_in),
        .carry_flag(carry_flag), .execution_error_flag(execution_error_flag),
        .block_op_busy_flag(block_op_busy_flag), .error_led(error_led));

    always #2 pclk = ~pclk;

    task automatic end_of_test();
        if (mismatches == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // compares read data with the oldest note
    always @(posedge pclk) begin
        cycles++;
        if (psel && penable && pready && !pwrite && want) begin
            check(name_q.pop_front(), prdata & m_q.pop_front(), exp_q.pop_front());
        end
        if (block_op_busy_flag) begin
            busy_seen <= 1'b1;
        end
        if (cycles > 40000) begin
            mismatches++;
            end_of_test();
        end
    end

    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
        input logic w, output logic [31:0] rdv);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        want <= w;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdv = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        want <= 1'b0;
        @(posedge pclk);
    endtask : xfer

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        xfer(1'b1, a, d, 1'b0, x);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n,
        input logic [31:0] m = 32'hFFFF_FFFF);
        logic [31:0] x;
        exp_q.push_back(e);
        m_q.push_back(m);
        name_q.push_back(n);
        xfer(1'b0, a, 32'h0000_0000, 1'b1, x);
    endtask : rd

    function automatic logic [11:0] mem_a(input int i);
        return 12'h100 + 12'(4 * i);
    endfunction : mem_a

    function automatic logic [31:0] cw(input shift_rotate_pkg::op_e op, input logic wide,
        input shift_rotate_pkg::src_e sa = shift_rotate_pkg::SRC_CONST,
        input shift_rotate_pkg::src_e sb = shift_rotate_pkg::SRC_CONST);
        return {20'h00000, sb, sa, 1'b0, wide, 1'b0, op};
    endfunction : cw

    // run until the word changes or, when err is set, an error shows, then stop
    task automatic run_op(input logic [31:0] ctrl, input int watch, input logic err);
        logic [31:0] old, v;
        int n;
        xfer(1'b0, mem_a(watch), 32'h0000_0000, 1'b0, old);
        wr(CT_OFS, ctrl | 32'h0000_0008);
        v = old;
        n = 0;
        while (v === old && !(err && execution_error_flag === 1'b1) && n < 800) begin
            xfer(1'b0, mem_a(watch), 32'h0000_0000, 1'b0, v);
            n++;
        end
        wr(CT_OFS, ctrl);
    endtask : run_op

    initial begin
        logic [31:0] v, e;
        int c;
        logic f;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        rd(CT_OFS, 32'h0000_0000, "ctrl reset");
        rd(ST_OFS, 32'h0000_0000, "status reset");
        rd(12'h020, 32'h0000_0000, "unmapped");
        for (int k = 0; k < 4; k++) begin
            v = $random(seed);
            c = 1 + ({$random(seed)} % 15);
            f = k[0];
            wr(shift_rotate_pkg::OPA_OFS, 32'h0000_0002);
            wr(shift_rotate_pkg::OPB_OFS, {31'h0000_0000, f});
            wr(shift_rotate_pkg::CNT_OFS, 32'(c));
            wr(mem_a(2), {16'h0000, v[15:0]});
            wr(mem_a(3), {16'h0000, v[31:16]});
            run_op(cw(shift_rotate_pkg::OP_SHIFT_RIGHT, 1'b0), 2, 1'b0);
            e = (v >> c) | (f ? ~(32'hFFFF_FFFF >> c) : 32'h0000_0000);
            rd(mem_a(2), {16'h0000, e[15:0]}, "shift low word");
            rd(mem_a(3), {16'h0000, e[31:16]}, "shift high word");
            rd(ST_OFS, {31'h0000_0000, v[c-1]}, "shift carry");
        end
        for (int k = 0; k < 4; k++) begin
            c = 1 + ({$random(seed)} % 15);
            f = k[0];
            if (f) c = 1 + ({$random(seed)} % 31);
            v = $random(seed);
            if (k == 0) begin
                v[15:0] = 16'hA006;
                c = 1;
            end
            wr(shift_rotate_pkg::OPA_OFS, 32'h0000_0006);
            wr(shift_rotate_pkg::CNT_OFS, 32'(c));
            wr(mem_a(6), {16'h0000, v[15:0]});
            wr(mem_a(7), {16'h0000, v[31:16]});
            run_op(cw(shift_rotate_pkg::OP_ROTATE_LEFT, f), 6, 1'b0);
            e = f ? ((v << c) | (v >> (32 - c)))
                : {v[31:16], (v[15:0] << c) | (v[15:0] >> (16 - c))};
            rd(mem_a(6), {16'h0000, e[15:0]}, "rotate low word");
            if (f) rd(mem_a(7), {16'h0000, e[31:16]}, "rotate high word");
            rd(ST_OFS, {31'h0000_0000, e[0]}, "rotate carry", 32'h0000_0001);
        end
        wr(shift_rotate_pkg::CNT_OFS, 32'h0000_0010);
        run_op(cw(shift_rotate_pkg::OP_ROTATE_LEFT, 1'b0), 6, 1'b1);
        rd(mem_a(6), {16'h0000, e[15:0]}, "rotate count error hold");
        rd(ST_OFS, 32'h0000_0002, "rotate count error", 32'h0000_0006);
        wr(ST_OFS, 32'h0000_0002);
        wr(mem_a(4), 32'h0000_007B);
        wr(mem_a(5), 32'h0000_11D7);
        wr(shift_rotate_pkg::OPA_OFS, 32'h0000_0004);
        wr(shift_rotate_pkg::RELAY_LO_OFS, 32'h0000_0100);
        for (int k = 0; k < 4; k++) begin
            wr(shift_rotate_pkg::OPB_OFS, k == 3 ? 32'h0000_0008 : 32'h0000_0001);
            run_op(cw(shift_rotate_pkg::OP_DECIMAL_LEFT, 1'b0, shift_rotate_pkg::SRC_CONST,
                dsrc[k]), 4, 1'b0);
            rd(mem_a(4), {16'h0000, dhi[k]}, "digit high word");
            rd(mem_a(5), {16'h0000, dlo[k]}, "digit low word");
        end
        wr(mem_a(4), 32'h0000_2710);
        wr(shift_rotate_pkg::OPB_OFS, 32'h0000_0001);
        run_op(cw(shift_rotate_pkg::OP_DECIMAL_LEFT, 1'b0), 4, 1'b1);
        rd(mem_a(4), 32'h0000_2710, "digit range hold");
        rd(ST_OFS, 32'h0000_0002, "digit range error", 32'h0000_0006);
        wr(ST_OFS, 32'h0000_0002);
        wr(mem_a(4), 32'h0000_04D2);
        wr(shift_rotate_pkg::OPB_OFS, 32'h0000_0008);
        run_op(cw(shift_rotate_pkg::OP_DECIMAL_LEFT, 1'b0), 4, 1'b1);
        rd(mem_a(4), 32'h0000_04D2, "digit count hold");
        rd(ST_OFS, 32'h0000_0002, "digit count error", 32'h0000_0006);
        wr(ST_OFS, 32'h0000_0002);
        for (int k = 0; k < 4; k++) wr(mem_a(10 + k), 32'h0000_0011 * (k + 1));
        wr(mem_a(20), 32'h0000_BEEF);
        wr(shift_rotate_pkg::OPA_OFS, 32'h0000_0014);
        wr(shift_rotate_pkg::OPB_OFS, 32'h0000_0003);
        wr(shift_rotate_pkg::DST_OFS, 32'h0000_000A);
        run_op(cw(shift_rotate_pkg::OP_WORD_BLOCK_SHIFT, 1'b0, shift_rotate_pkg::SRC_MEM), 10,
            1'b0);
        check("busy during block shift", {31'h0000_0000, busy_seen}, 32'h0000_0001);
        rd(mem_a(10), 32'h0000_BEEF, "block first word");
        for (int k = 1; k < 4; k++) rd(mem_a(10 + k), 32'h0000_0011 * k, "block word");
        rd(ST_OFS, 32'h0000_0000, "block busy clear", 32'h0000_0006);
        busy_retained_in <= 1'b1;
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        rd(ST_OFS, 32'h0000_0004, "busy kept over power loss");
        wr(ST_OFS, 32'h0000_0004);
        rd(ST_OFS, 32'h0000_0000, "busy cleared");
        end_of_test();
    end
endmodule : tb

/* design/bcd_word.sv */
`timescale 1ns/1ps
module bcd_word (
    input wire logic [15:0] bin_in,
    output logic [15:0] bcd_out,
    input wire logic [15:0] bcd_in,
    output logic [15:0] bin_out
);
    wire [15:0] th = bin_in / 16'd1000;
    wire [15:0] hu = (bin_in / 16'd100) % 16'd10;
    wire [15:0] te = (bin_in / 16'd10) % 16'd10;
    wire [15:0] on = bin_in % 16'd10;

    assign bcd_out = {th[3:0], hu[3:0], te[3:0], on[3:0]};
    assign bin_out = 16'(bcd_in[15:12] * 16'd1000 + bcd_in[11:8] * 16'd100
                        + bcd_in[7:4] * 16'd10 + bcd_in[3:0]);
endmodule : bcd_word

/* design/operand_fetch.sv */
`timescale 1ns/1ps
module operand_fetch (
    input wire shift_rotate_pkg::src_e sel,
    input wire logic [5:0] addr,
    input wire logic [15:0] konst,
    input wire logic [15:0] mem_word,
    input wire logic [15:0] timer_pv,
    input wire logic [15:0] counter_pv,
    input wire logic [63:0] relay_bits,
    output logic [15:0] word
);
    wire [63:0] gathered = relay_bits >> addr;

    assign word = (sel == shift_rotate_pkg::SRC_MEM) ? mem_word :
                  (sel == shift_rotate_pkg::SRC_TIMER) ? timer_pv :
                  (sel == shift_rotate_pkg::SRC_COUNTER) ? counter_pv :
                  (sel == shift_rotate_pkg::SRC_BITS) ? gathered[15:0] :
                  konst;
endmodule : operand_fetch

/* design/shift_rotate_pkg.sv */
package shift_rotate_pkg;
    localparam int ADDR_W = 6;
    localparam int MEM_WORDS = 64;
    localparam int RELAY_BITS = 64;

    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] STATUS_OFS = 12'h004;
    localparam logic [11:0] OPA_OFS = 12'h008;
    localparam logic [11:0] OPB_OFS = 12'h00C;
    localparam logic [11:0] DST_OFS = 12'h010;
    localparam logic [11:0] CNT_OFS = 12'h014;
    localparam logic [11:0] RELAY_LO_OFS = 12'h018;
    localparam logic [11:0] RELAY_HI_OFS = 12'h01C;
    localparam logic [3:0] MEM_PAGE = 4'h1;

    localparam int ST_CARRY_BIT = 0;
    localparam int ST_ERROR_BIT = 1;
    localparam int ST_BUSY_BIT = 2;

    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [15:0] WORD_RESET = 16'h0000;

    localparam int CLK_PERIOD_NS = 4;
    localparam int SCAN_TIME_NS = 4000;
    localparam int SCAN_CYCLES = SCAN_TIME_NS / CLK_PERIOD_NS;

    localparam logic [15:0] SHIFT_MAX_BITS = 16'h000F;
    localparam logic [15:0] BCD_MAX_DIGITS = 16'h0007;
    localparam logic [15:0] BCD_WORD_MAX = 16'h270F;
    localparam logic [15:0] ROT16_MAX = 16'h000F;
    localparam logic [15:0] ROT32_MAX = 16'h001F;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_SHIFT_RIGHT = 3'h1,
        OP_DECIMAL_LEFT = 3'h2,
        OP_WORD_BLOCK_SHIFT = 3'h3,
        OP_ROTATE_LEFT = 3'h4,
        OP_BLOCK_MOVE = 3'h5
    } op_e;

    typedef enum logic [2:0] {
        SRC_CONST = 3'h0,
        SRC_MEM = 3'h1,
        SRC_TIMER = 3'h2,
        SRC_COUNTER = 3'h3,
        SRC_BITS = 3'h4
    } src_e;

    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_BLOCK = 3'b010,
        S_LAST = 3'b100
    } state_e;

    typedef struct packed {
        logic [19:0] rsvd;
        src_e src_b;
        src_e src_a;
        logic bit_target;
        logic wide;
        logic run;
        op_e op;
    } ctrl_s;
endpackage : shift_rotate_pkg

/* design/shift_rotate_word_unit.sv */
`timescale 1ns/1ps
module shift_rotate_word_unit (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] timer_present_value,
    input wire logic [15:0] counter_present_value,
    input wire logic busy_retained_in,
    output logic carry_flag,
    output logic execution_error_flag,
    output logic block_op_busy_flag,
    output logic error_led
);
    localparam logic [9:0] SCAN_LAST = 10'(shift_rotate_pkg::SCAN_CYCLES - 1);

    logic [15:0] mem [0:shift_rotate_pkg::MEM_WORDS-1];
    shift_rotate_pkg::ctrl_s ctrl_reg;
    shift_rotate_pkg::state_e state_reg;
    logic [5:0] opa_reg, dst_reg, idx_reg;
    logic [15:0] opb_reg, cnt_reg, src_lat_reg;
    logic [63:0] relay_reg;
    logic [9:0] scan_cnt_reg;
    logic carry_reg, err_reg, busy_reg, restore_reg, rd_ok_reg;
    logic [31:0] prdata_reg;

    // scan divider: operations fire once per scan while run is set
    wire scan_tick = (scan_cnt_reg == SCAN_LAST);
    wire idle = (state_reg == shift_rotate_pkg::S_IDLE);
    wire exec_now = scan_tick & ctrl_reg.run & idle & ~restore_reg;
    wire quiet = idle & ~exec_now;

    // register bus decode
    wire hit_ctrl = (paddr == shift_rotate_pkg::CTRL_OFS);
    wire hit_status = (paddr == shift_rotate_pkg::STATUS_OFS);
    wire hit_opa = (paddr == shift_rotate_pkg::OPA_OFS);
    wire hit_opb = (paddr == shift_rotate_pkg::OPB_OFS);
    wire hit_dst = (paddr == shift_rotate_pkg::DST_OFS);
    wire hit_cnt = (paddr == shift_rotate_pkg::CNT_OFS);
    wire hit_rlo = (paddr == shift_rotate_pkg::RELAY_LO_OFS);
    wire hit_rhi = (paddr == shift_rotate_pkg::RELAY_HI_OFS);
    wire hit_mem = (paddr[11:8] == shift_rotate_pkg::MEM_PAGE) & (paddr[1:0] == 2'b00);
    wire [5:0] mem_idx = paddr[7:2];
    wire addr_ok = hit_ctrl | hit_status | hit_opa | hit_opb | hit_dst | hit_cnt
                   | hit_rlo | hit_rhi | hit_mem;
    wire xfer = psel & penable & pready;
    wire wr_en = xfer & pwrite & addr_ok;
    wire [31:0] status_word = {29'h0, busy_reg, err_reg, carry_reg};
    wire [31:0] rd_data = hit_ctrl ? ctrl_reg :
                          hit_status ? status_word :
                          hit_opa ? {26'h0, opa_reg} :
                          hit_opb ? {16'h0, opb_reg} :
                          hit_dst ? {26'h0, dst_reg} :
                          hit_cnt ? {16'h0, cnt_reg} :
                          hit_rlo ? relay_reg[31:0] :
                          hit_rhi ? relay_reg[63:32] :
                          hit_mem ? {16'h0, mem[mem_idx]} : 32'h0;

    assign pready = quiet & (pwrite | rd_ok_reg);
    assign pslverr = pready & ~addr_ok;
    assign prdata = prdata_reg;

    // operand words: first word low, following word high
    wire [5:0] opa_next = 6'(opa_reg + 6'd1);
    wire [15:0] a0 = mem[opa_reg];
    wire [15:0] a1 = mem[opa_next];
    wire [31:0] v32 = {a1, a0};
    wire [15:0] word_a, word_b;

    operand_fetch fetch_a (
        .sel(ctrl_reg.src_a),
        .addr(opa_reg),
        .konst(opb_reg),
        .mem_word(a0),
        .timer_pv(timer_present_value),
        .counter_pv(counter_present_value),
        .relay_bits(relay_reg),
        .word(word_a)
    );

    operand_fetch fetch_b (
        .sel(ctrl_reg.src_b),
        .addr(opb_reg[5:0]),
        .konst(opb_reg),
        .mem_word(mem[opb_reg[5:0]]),
        .timer_pv(timer_present_value),
        .counter_pv(counter_present_value),
        .relay_bits(relay_reg),
        .word(word_b)
    );

    // right shift of the 32-bit string
    wire [4:0] sh_n = cnt_reg[4:0];
    wire sh_err = (cnt_reg == 16'h0000) | (cnt_reg > shift_rotate_pkg::SHIFT_MAX_BITS);
    wire fill = word_b[0];
    wire [31:0] fill_mask = ~(32'hFFFF_FFFF >> sh_n);
    wire [31:0] sh_res = (v32 >> sh_n) | (fill ? fill_mask : 32'h0);
    wire [31:0] sh_pick = v32 >> (5'(sh_n - 5'd1));
    wire sh_carry = sh_pick[0];

    // decimal digit shift: first word holds the four high digits
    wire [15:0] bcd_hi, bcd_lo, bin_hi, bin_lo;
    wire [31:0] digits = {bcd_hi, bcd_lo};
    wire [4:0] dig_bits = {word_b[2:0], 2'b00};
    wire [31:0] digits_sh = digits << dig_bits;
    wire bcd_range_err = (a0 > shift_rotate_pkg::BCD_WORD_MAX)
                         | (a1 > shift_rotate_pkg::BCD_WORD_MAX);
    wire bcd_cnt_err = (word_b > shift_rotate_pkg::BCD_MAX_DIGITS)
                       | (word_b == 16'h0000);
    wire bcd_err = bcd_range_err | bcd_cnt_err;

    bcd_word conv_hi (
        .bin_in(a0),
        .bcd_out(bcd_hi),
        .bcd_in(digits_sh[31:16]),
        .bin_out(bin_hi)
    );

    bcd_word conv_lo (
        .bin_in(a1),
        .bcd_out(bcd_lo),
        .bcd_in(digits_sh[15:0]),
        .bin_out(bin_lo)
    );

    // left rotate on memory words or on bit points of the relay area
    wire [63:0] relay_view = relay_reg >> opa_reg;
    wire [31:0] rot_src = ctrl_reg.bit_target ? relay_view[31:0] : v32;
    wire [4:0] rot_n = cnt_reg[4:0];
    wire [15:0] rot_lim = ctrl_reg.wide ? shift_rotate_pkg::ROT32_MAX
                                        : shift_rotate_pkg::ROT16_MAX;
    wire rot_err = (cnt_reg == 16'h0000) | (cnt_reg > rot_lim);
    wire [31:0] rot32 = (rot_src << rot_n) | (rot_src >> (6'd32 - {1'b0, rot_n}));
    wire [15:0] rot16 = (rot_src[15:0] << rot_n)
                        | (rot_src[15:0] >> (5'd16 - rot_n));
    wire [31:0] rot_res = ctrl_reg.wide ? rot32 : {rot_src[31:16], rot16};
    wire rot_carry = rot_res[0];
    wire [63:0] rot_mask = (ctrl_reg.wide ? 64'h0000_0000_FFFF_FFFF
                                          : 64'h0000_0000_0000_FFFF) << opa_reg;
    wire [63:0] rot_ins = {32'h0, rot_res} << opa_reg;

    // block operations: length checked against the memory end
    wire [6:0] blk_end = {1'b0, dst_reg} + 7'(word_b);
    wire [6:0] mov_end = {1'b0, opa_reg} + 7'(word_b);
    wire is_word_block_shift_op = (ctrl_reg.op == shift_rotate_pkg::OP_WORD_BLOCK_SHIFT);
    wire is_block_move_op = (ctrl_reg.op == shift_rotate_pkg::OP_BLOCK_MOVE);
    wire blk_err = (word_b == 16'h0000) | (word_b > 16'd64)
                   | (is_word_block_shift_op & (blk_end > 7'd63)) | (is_block_move_op & (blk_end > 7'd64))
                   | (is_block_move_op & (mov_end > 7'd64));

    logic op_err;
    always_comb begin
        case (ctrl_reg.op)
            shift_rotate_pkg::OP_SHIFT_RIGHT: op_err = sh_err;
            shift_rotate_pkg::OP_DECIMAL_LEFT: op_err = bcd_err;
            shift_rotate_pkg::OP_ROTATE_LEFT: op_err = rot_err;
            shift_rotate_pkg::OP_WORD_BLOCK_SHIFT: op_err = blk_err;
            shift_rotate_pkg::OP_BLOCK_MOVE: op_err = blk_err;
            default: op_err = 1'b0;
        endcase
    end

    wire do_op = exec_now & ~op_err;
    wire blk_start = do_op & (is_word_block_shift_op | is_block_move_op);
    wire do_sh = do_op & (ctrl_reg.op == shift_rotate_pkg::OP_SHIFT_RIGHT);
    wire do_bcd = do_op & (ctrl_reg.op == shift_rotate_pkg::OP_DECIMAL_LEFT);
    wire do_rot = do_op & (ctrl_reg.op == shift_rotate_pkg::OP_ROTATE_LEFT);
    wire rot_mem = do_rot & ~ctrl_reg.bit_target;
    wire rot_bits = do_rot & ctrl_reg.bit_target;
    wire in_block = (state_reg == shift_rotate_pkg::S_BLOCK);
    wire in_last = (state_reg == shift_rotate_pkg::S_LAST);
    wire blk_done = in_block & (is_word_block_shift_op ? (idx_reg == 6'h00) : (idx_reg == 6'(word_b - 16'd1)));

    // word block shift walks downward, block move walks upward
    wire [5:0] word_block_shift_op_from = 6'(dst_reg + idx_reg);
    wire [5:0] word_block_shift_op_to = 6'(dst_reg + idx_reg + 6'd1);
    wire [5:0] mov_from = 6'(opa_reg + idx_reg);
    wire blk_we = in_block;
    wire [5:0] blk_waddr = is_word_block_shift_op ? word_block_shift_op_to : word_block_shift_op_from;
    wire [15:0] blk_wdata = is_word_block_shift_op ? mem[word_block_shift_op_from] : mem[mov_from];

    // memory: operation writes take the slot, bus writes wait for quiet cycles
    always_ff @(posedge pclk) begin
        if (wr_en & hit_mem) begin
            mem[mem_idx] <= pwdata[15:0];
        end
        if (do_sh) begin
            mem[opa_reg] <= sh_res[15:0];
            mem[opa_next] <= sh_res[31:16];
        end
        if (do_bcd) begin
            mem[opa_reg] <= bin_hi;
            mem[opa_next] <= bin_lo;
        end
        if (rot_mem) begin
            mem[opa_reg] <= rot_res[15:0];
            if (ctrl_reg.wide) begin
                mem[opa_next] <= rot_res[31:16];
            end
        end
        if (blk_we) begin
            mem[blk_waddr] <= blk_wdata;
        end
        if (in_last) begin
            mem[dst_reg] <= src_lat_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scan_cnt_reg <= 10'h000;
        end else begin
            scan_cnt_reg <= scan_tick ? 10'h000 : 10'(scan_cnt_reg + 10'h001);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= shift_rotate_pkg::CTRL_RESET;
            opa_reg <= 6'h00;
            opb_reg <= shift_rotate_pkg::WORD_RESET;
            dst_reg <= 6'h00;
            cnt_reg <= shift_rotate_pkg::WORD_RESET;
        end else if (wr_en) begin
            if (hit_ctrl) ctrl_reg <= {20'h0, pwdata[11:0]};
            if (hit_opa) opa_reg <= pwdata[5:0];
            if (hit_opb) opb_reg <= pwdata[15:0];
            if (hit_dst) dst_reg <= pwdata[5:0];
            if (hit_cnt) cnt_reg <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            relay_reg <= 64'h0;
        end else if (rot_bits) begin
            relay_reg <= (relay_reg & ~rot_mask) | (rot_ins & rot_mask);
        end else if (wr_en & hit_rlo) begin
            relay_reg[31:0] <= pwdata;
        end else if (wr_en & hit_rhi) begin
            relay_reg[63:32] <= pwdata;
        end
    end

    // block sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= shift_rotate_pkg::S_IDLE;
            idx_reg <= 6'h00;
            src_lat_reg <= shift_rotate_pkg::WORD_RESET;
        end else begin
            case (state_reg)
                shift_rotate_pkg::S_IDLE: begin
                    if (blk_start) begin
                        state_reg <= shift_rotate_pkg::S_BLOCK;
                        idx_reg <= is_word_block_shift_op ? 6'(word_b - 16'd1) : 6'h00;
                        src_lat_reg <= word_a;
                    end
                end
                shift_rotate_pkg::S_BLOCK: begin
                    if (blk_done) begin
                        state_reg <= is_word_block_shift_op ? shift_rotate_pkg::S_LAST
                                             : shift_rotate_pkg::S_IDLE;
                    end else begin
                        idx_reg <= is_word_block_shift_op ? 6'(idx_reg - 6'd1) : 6'(idx_reg + 6'd1);
                    end
                end
                shift_rotate_pkg::S_LAST: begin
                    state_reg <= shift_rotate_pkg::S_IDLE;
                end
                default: begin
                    state_reg <= shift_rotate_pkg::S_IDLE;
                end
            endcase
        end
    end

    // flags: hardware set wins over software clear
    wire clr_err = wr_en & hit_status & pwdata[shift_rotate_pkg::ST_ERROR_BIT];
    wire clr_busy = wr_en & hit_status & pwdata[shift_rotate_pkg::ST_BUSY_BIT];
    wire blk_finish = (in_block & blk_done & is_block_move_op) | in_last;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            carry_reg <= 1'b0;
            err_reg <= 1'b0;
            busy_reg <= 1'b0;
            restore_reg <= 1'b1;
        end else begin
            restore_reg <= 1'b0;
            if (do_sh) carry_reg <= sh_carry;
            else if (do_rot) carry_reg <= rot_carry;
            if (exec_now & op_err) err_reg <= 1'b1;
            else if (clr_err) err_reg <= 1'b0;
            if (restore_reg) busy_reg <= busy_retained_in;
            else if (blk_start) busy_reg <= 1'b1;
            else if (blk_finish | clr_busy) busy_reg <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0;
            rd_ok_reg <= 1'b0;
        end else begin
            rd_ok_reg <= psel & quiet & ~xfer;
            if (psel & quiet) prdata_reg <= rd_data;
        end
    end

    assign carry_flag = carry_reg;
    assign execution_error_flag = err_reg;
    assign block_op_busy_flag = busy_reg;
    assign error_led = err_reg;
endmodule : shift_rotate_word_unit
